// ### hw/aod_regs.svh
// Constants of the analog output parameter and diagnostic block
// Summary of operation
// - Per-channel wire-break enable, bits 0 and 1
// - Controller raises codes 0 to 99 to 100 where wire-break is enabled
// - Function code FFh deactivates the channel
// - Accept range codes 31h, 41h, 30h, 40h
// - Format A: 27648 full scale, 32511 overrange
// - Format B: 16384 full scale, 20480 overrange
// - 4-20 mA: underrange to -6912 or -4096
// - 0-20 mA: negative codes clamp to 0 mA
// - Fault lights channel LED, recorded, no interrupt
// - Report only configuration and wire-break faults
// - Record 01h full, record 00h first four
// - Index 2F01h full, index 2F00h first four
// - Index 5005h, one subindex per item
// - Fixed bytes 73h, 08h, 02h
// - Module information 15h: class and channel bit
// - Channel error byte: bit 0 config, 4 wire-break
// - Group error byte: bit per channel group
// - Microsecond counter wraps, stamped at each fault
`ifndef AOD_REGS_SVH
`define AOD_REGS_SVH
`define AOD_FN_A_020 8'h31
`define AOD_FN_B_020 8'h41
`define AOD_FN_A_420 8'h30
`define AOD_FN_B_420 8'h40
`define AOD_FN_OFF 8'hFF
`define AOD_FN_RESET 8'h31
`define AOD_WBE_RESET 8'h00
`define AOD_FS_A 32'sd27648
`define AOD_OVR_A 32'sd32511
`define AOD_UND_A 32'sd6912
`define AOD_FS_B 32'sd16384
`define AOD_OVR_B 32'sd20480
`define AOD_UND_B 32'sd4096
`define AOD_SPAN_020_UA 32'sd20000
`define AOD_SPAN_420_UA 32'sd16000
`define AOD_BASE_420_UA 32'sd4000
`define AOD_WB_MIN_CODE 16'sh0064
`define AOD_MODINFO 8'h15
`define AOD_CHKIND 8'h73
`define AOD_DIAG_BITS_PER_CHANNEL 8'h08
`define AOD_CHANNEL_COUNT 8'h02
`define AOD_ERR_CFG_BIT 0
`define AOD_ERR_WB_BIT 4
`define AOD_SUM_ANY_BIT 0
`define AOD_SUM_CH_BIT 3
`define AOD_PREC_WBE 16'h0000
`define AOD_PREC_CH0 16'h0080
`define AOD_PREC_CH1 16'h0081
`define AOD_PIDX_WBE 16'h3101
`define AOD_PIDX_CH0 16'h3102
`define AOD_PIDX_CH1 16'h3103
`define AOD_PSUB_WBE 16'h0002
`define AOD_PSUB_CH0 16'h0003
`define AOD_PSUB_CH1 16'h0004
`define AOD_DREC_FULL 16'h0001
`define AOD_DREC_HEAD 16'h0000
`define AOD_DIDX_FULL 16'h2F01
`define AOD_DIDX_HEAD 16'h2F00
`define AOD_DSUB_INDEX 16'h5005
`define AOD_DSUB_FIRST 16'h0002
`define AOD_DSUB_LAST 16'h0011
`define AOD_DSUB_STAMP 16'h0013
`define AOD_DIAG_BYTES 20
`define AOD_DIAG_HEAD 4
`define AOD_DIAG_STAMP 16
`define AOD_CLK_NS 25
`define AOD_US_NS 1000
`endif

// ### hw/aod_pkg.sv
// Types shared by both ends of the analog output diagnostic link
package aod_pkg;
  typedef enum logic [0:0] {
    AOD_PARAM_WR = 1'b0,
    AOD_DIAG_RD = 1'b1
  } aod_kind_e;

  typedef enum logic [1:0] {
    AOD_BY_RECORD = 2'b00,
    AOD_BY_INDEX = 2'b01,
    AOD_BY_SUBINDEX = 2'b10
  } aod_mode_e;

  typedef enum logic [1:0] {
    AOD_H_IDLE = 2'b00,
    AOD_H_REQ = 2'b01,
    AOD_H_WAIT = 2'b10
  } aod_hstate_e;

  typedef struct packed {
    logic [7:0] wire_break_enable;
    logic [1:0][7:0] channel_function_code;
    logic [1:0][15:0] code;
    logic [1:0][15:0] current_ua;
    logic [1:0] active;
    logic [1:0][7:0] error_flags;
    logic [1:0] wb_meta;
    logic [1:0] wb_sync;
    logic [31:0] us_count;
    logic [5:0] us_div;
    logic [31:0] diag_timestamp_us;
    logic ack;
    logic nak;
    logic [7:0] rdata;
  } aod_dev_s;

  typedef struct packed {
    aod_hstate_e st;
    logic [1:0] wbe_shadow;
    logic kind;
    logic [1:0] mode;
    logic [15:0] key;
    logic [4:0] sel;
    logic [7:0] wdata;
    logic [1:0][15:0] code;
    logic out_valid;
    logic rsp_valid;
    logic rsp_err;
    logic [7:0] rsp_data;
  } aod_host_s;
endpackage

// ### hw/aod_link_if.sv
// Record access and process data link between controller and module
interface aod_link_if;
  logic req;
  logic kind;
  logic [1:0] mode;
  logic [15:0] key;
  logic [4:0] sel;
  logic [7:0] wdata;
  logic ack;
  logic nak;
  logic [7:0] rdata;
  logic out_valid;
  logic [15:0] out_code0;
  logic [15:0] out_code1;

  modport device (
    input req, kind, mode, key, sel, wdata, out_valid, out_code0, out_code1,
    output ack, nak, rdata
  );
  modport host (
    output req, kind, mode, key, sel, wdata, out_valid, out_code0, out_code1,
    input ack, nak, rdata
  );
endinterface

// ### hw/aod_host.sv
// Controller end: issues record accesses and output codes
`include "aod_regs.svh"
module aod_host (
  input wire logic clk,
  input wire logic rst,
  aod_link_if.host link,
  input wire logic cmd_valid,
  input wire logic cmd_kind,
  input wire logic [1:0] cmd_mode,
  input wire logic [15:0] cmd_key,
  input wire logic [4:0] cmd_sel,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic rsp_err,
  output logic [7:0] rsp_data,
  input wire logic code_valid,
  input wire logic [15:0] code0,
  input wire logic [15:0] code1
);
  aod_pkg::aod_host_s r;
  aod_pkg::aod_host_s next_r;

  // Low codes make wire-break detection unreliable, so they are raised
  function automatic logic [15:0] lift(input logic [15:0] c, input logic en);
    lift = (en && $signed(c) >= 0 && $signed(c) < `AOD_WB_MIN_CODE) ?
      `AOD_WB_MIN_CODE : c;
  endfunction

  function automatic logic is_wbe_write(input aod_pkg::aod_host_s s);
    is_wbe_write = s.kind == aod_pkg::AOD_PARAM_WR && (
      (s.mode == aod_pkg::AOD_BY_RECORD && s.key == `AOD_PREC_WBE && s.sel == 5'h01) ||
      (s.mode == aod_pkg::AOD_BY_INDEX && s.key == `AOD_PIDX_WBE) ||
      (s.mode == aod_pkg::AOD_BY_SUBINDEX && s.key == `AOD_PSUB_WBE));
  endfunction

  always_comb begin
    next_r = r;
    next_r.rsp_valid = 1'b0;
    next_r.out_valid = 1'b0;
    if (code_valid) begin
      next_r.code[0] = lift(code0, r.wbe_shadow[0]);
      next_r.code[1] = lift(code1, r.wbe_shadow[1]);
      next_r.out_valid = 1'b1;
    end
    case (r.st)
      aod_pkg::AOD_H_IDLE: begin
        if (cmd_valid) begin
          next_r.kind = cmd_kind;
          next_r.mode = cmd_mode;
          next_r.key = cmd_key;
          next_r.sel = cmd_sel;
          next_r.wdata = cmd_wdata;
          next_r.st = aod_pkg::AOD_H_REQ;
        end
      end
      aod_pkg::AOD_H_REQ: begin
        next_r.st = aod_pkg::AOD_H_WAIT;
      end
      aod_pkg::AOD_H_WAIT: begin
        if (link.ack) begin
          next_r.rsp_valid = 1'b1;
          next_r.rsp_err = link.nak;
          next_r.rsp_data = link.rdata;
          if (is_wbe_write(r) && !link.nak) begin
            next_r.wbe_shadow = r.wdata[1:0];
          end
          next_r.st = aod_pkg::AOD_H_IDLE;
        end
      end
      default: begin
        next_r.st = aod_pkg::AOD_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
      r.st <= aod_pkg::AOD_H_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign cmd_ready = r.st == aod_pkg::AOD_H_IDLE;
  assign link.req = r.st == aod_pkg::AOD_H_REQ;
  assign link.kind = r.kind;
  assign link.mode = r.mode;
  assign link.key = r.key;
  assign link.sel = r.sel;
  assign link.wdata = r.wdata;
  assign link.out_valid = r.out_valid;
  assign link.out_code0 = r.code[0];
  assign link.out_code1 = r.code[1];
  assign rsp_valid = r.rsp_valid;
  assign rsp_err = r.rsp_err;
  assign rsp_data = r.rsp_data;
endmodule

// ### hw/aod_device.sv
// Module end: parameters, code to current conversion and diagnostics
`include "aod_regs.svh"
module aod_device #(
  parameter int CLK_NS = `AOD_CLK_NS
) (
  input wire logic clk,
  input wire logic rst,
  aod_link_if.device link,
  input wire logic [1:0] wire_open,
  output logic [15:0] current_ua0,
  output logic [15:0] current_ua1,
  output logic [1:0] chan_active,
  output logic [1:0] err_led
);
  localparam int US_CYCLES = `AOD_US_NS / CLK_NS;

  if (CLK_NS < 1 || US_CYCLES < 2 || US_CYCLES > 64 ||
      (`AOD_US_NS % CLK_NS) != 0) begin : g_bad_clock
    $error("clock period cannot produce a whole microsecond tick");
  end

  aod_pkg::aod_dev_s r;
  aod_pkg::aod_dev_s next_r;

  function automatic logic fn_known(input logic [7:0] fn);
    fn_known = fn == `AOD_FN_A_020 || fn == `AOD_FN_B_020 ||
      fn == `AOD_FN_A_420 || fn == `AOD_FN_B_420;
  endfunction

  // Whole-microampere result; the divide by a constant full scale is
  // kept exact rather than approximated by shifts.
  function automatic logic [15:0] to_ua(input logic [7:0] fn, input logic [15:0] code);
    logic signed [31:0] d;
    logic signed [31:0] fs;
    logic signed [31:0] hi;
    logic signed [31:0] lo;
    logic signed [31:0] ua;
    logic fmt_b;
    logic live_zero;
    d = 32'($signed(code));
    fmt_b = fn == `AOD_FN_B_020 || fn == `AOD_FN_B_420;
    live_zero = fn == `AOD_FN_A_420 || fn == `AOD_FN_B_420;
    fs = fmt_b ? `AOD_FS_B : `AOD_FS_A;
    hi = fmt_b ? `AOD_OVR_B : `AOD_OVR_A;
    lo = live_zero ? -(fmt_b ? `AOD_UND_B : `AOD_UND_A) : 32'sd0;
    if (d > hi) begin
      d = hi;
    end
    if (d < lo) begin
      d = lo;
    end
    if (live_zero) begin
      ua = `AOD_BASE_420_UA + (d * `AOD_SPAN_420_UA) / fs;
    end else begin
      ua = (d * `AOD_SPAN_020_UA) / fs;
    end
    if (ua < 0) begin
      ua = 32'sd0;
    end
    to_ua = ua[15:0];
  endfunction

  // Maps a diagnostic access to a byte of the 20-byte record; bit 5
  // flags an address that names no item.
  function automatic logic [5:0] diag_pos(input logic [1:0] mode, input logic [15:0] key,
                                           input logic [4:0] sel);
    diag_pos = 6'h20;
    case (mode)
      aod_pkg::AOD_BY_RECORD: begin
        if (key == `AOD_DREC_FULL && sel < 5'(`AOD_DIAG_BYTES)) begin
          diag_pos = {1'b0, sel};
        end else if (key == `AOD_DREC_HEAD && sel < 5'(`AOD_DIAG_HEAD)) begin
          diag_pos = {1'b0, sel};
        end
      end
      aod_pkg::AOD_BY_INDEX: begin
        if (key == `AOD_DIDX_FULL && sel < 5'(`AOD_DIAG_BYTES)) begin
          diag_pos = {1'b0, sel};
        end else if (key == `AOD_DIDX_HEAD && sel < 5'(`AOD_DIAG_HEAD)) begin
          diag_pos = {1'b0, sel};
        end
      end
      aod_pkg::AOD_BY_SUBINDEX: begin
        // Key carries the subindex; sel picks the byte of the timestamp
        if (key >= `AOD_DSUB_FIRST && key <= `AOD_DSUB_LAST) begin
          diag_pos = 6'(key - `AOD_DSUB_FIRST);
        end else if (key == `AOD_DSUB_STAMP && sel < 5'h04) begin
          diag_pos = 6'(`AOD_DIAG_STAMP) + {4'h0, sel[1:0]};
        end
      end
      default: begin
        diag_pos = 6'h20;
      end
    endcase
  endfunction

  // 0 none, 1 wire-break enable, 2 channel 0, 3 channel 1
  function automatic logic [1:0] param_target(input logic [1:0] mode,
                                               input logic [15:0] key, input logic [4:0] sel);
    param_target = 2'h0;
    case (mode)
      aod_pkg::AOD_BY_RECORD: begin
        if (key == `AOD_PREC_WBE && sel == 5'h01) begin
          param_target = 2'h1;
        end else if (key == `AOD_PREC_CH0 && sel == 5'h00) begin
          param_target = 2'h2;
        end else if (key == `AOD_PREC_CH1 && sel == 5'h00) begin
          param_target = 2'h3;
        end
      end
      aod_pkg::AOD_BY_INDEX: begin
        if (key == `AOD_PIDX_WBE) begin
          param_target = 2'h1;
        end else if (key == `AOD_PIDX_CH0) begin
          param_target = 2'h2;
        end else if (key == `AOD_PIDX_CH1) begin
          param_target = 2'h3;
        end
      end
      aod_pkg::AOD_BY_SUBINDEX: begin
        if (key == `AOD_PSUB_WBE) begin
          param_target = 2'h1;
        end else if (key == `AOD_PSUB_CH0) begin
          param_target = 2'h2;
        end else if (key == `AOD_PSUB_CH1) begin
          param_target = 2'h3;
        end
      end
      default: begin
        param_target = 2'h0;
      end
    endcase
  endfunction

  logic [1:0] grp_err;
  logic [7:0] summary;
  logic [19:0][7:0] record;
  logic [1:0][7:0] flags_now;
  logic [5:0] pos;
  logic [1:0] tgt;

  // Fault flags follow the present condition, not a latched history.
  // One process fills both channels so the flag word has a single writer.
  always_comb begin
    flags_now = '0;
    for (int ch = 0; ch < 2; ch++) begin
      flags_now[ch][`AOD_ERR_CFG_BIT] = !fn_known(r.channel_function_code[ch]) &&
        r.channel_function_code[ch] != `AOD_FN_OFF;
      flags_now[ch][`AOD_ERR_WB_BIT] = r.wire_break_enable[ch] && r.wb_sync[ch] &&
        fn_known(r.channel_function_code[ch]);
    end
  end

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    assign grp_err[ch] = |r.error_flags[ch];
  end

  always_comb begin
    summary = 8'h00;
    summary[`AOD_SUM_ANY_BIT] = |grp_err;
    summary[`AOD_SUM_CH_BIT] = |grp_err;
    record = '0;
    record[0] = summary;
    record[1] = `AOD_MODINFO;
    record[4] = `AOD_CHKIND;
    record[5] = `AOD_DIAG_BITS_PER_CHANNEL;
    record[6] = `AOD_CHANNEL_COUNT;
    record[7] = {6'h00, grp_err};
    record[8] = r.error_flags[0];
    record[9] = r.error_flags[1];
    record[16] = r.diag_timestamp_us[7:0];
    record[17] = r.diag_timestamp_us[15:8];
    record[18] = r.diag_timestamp_us[23:16];
    record[19] = r.diag_timestamp_us[31:24];
  end

  assign pos = diag_pos(link.mode, link.key, link.sel);
  assign tgt = param_target(link.mode, link.key, link.sel);

  always_comb begin
    next_r = r;
    next_r.wb_meta = wire_open;
    next_r.wb_sync = r.wb_meta;
    // Free-running microsecond count, wraps naturally at 32 bits
    if (r.us_div == 6'(US_CYCLES - 1)) begin
      next_r.us_div = 6'h00;
      next_r.us_count = r.us_count + 32'h1;
    end else begin
      next_r.us_div = r.us_div + 6'h01;
    end
    next_r.error_flags = flags_now;
    if ((flags_now[0] & ~r.error_flags[0]) != 8'h00 ||
        (flags_now[1] & ~r.error_flags[1]) != 8'h00) begin
      next_r.diag_timestamp_us = r.us_count;
    end
    if (link.out_valid) begin
      next_r.code[0] = link.out_code0;
      next_r.code[1] = link.out_code1;
    end
    for (int ch = 0; ch < 2; ch++) begin
      next_r.active[ch] = fn_known(r.channel_function_code[ch]);
      next_r.current_ua[ch] = next_r.active[ch] ?
        to_ua(r.channel_function_code[ch], r.code[ch]) : 16'h0000;
    end
    next_r.ack = 1'b0;
    next_r.nak = 1'b0;
    if (link.req) begin
      next_r.ack = 1'b1;
      next_r.rdata = 8'h00;
      if (link.kind == aod_pkg::AOD_DIAG_RD) begin
        if (pos[5]) begin
          next_r.nak = 1'b1;
        end else begin
          next_r.rdata = record[pos[4:0]];
        end
      end else begin
        case (tgt)
          2'h1: next_r.wire_break_enable = {6'h00, link.wdata[1:0]};
          2'h2: next_r.channel_function_code[0] = link.wdata;
          2'h3: next_r.channel_function_code[1] = link.wdata;
          default: next_r.nak = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
      r.wire_break_enable <= `AOD_WBE_RESET;
      r.channel_function_code[0] <= `AOD_FN_RESET;
      r.channel_function_code[1] <= `AOD_FN_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign link.ack = r.ack;
  assign link.nak = r.nak;
  assign link.rdata = r.rdata;
  assign current_ua0 = r.current_ua[0];
  assign current_ua1 = r.current_ua[1];
  assign chan_active = r.active;
  assign err_led = grp_err;
endmodule

// ### tb/aod_properties.sv
// Link timing and diagnostic record content properties between the two ends
module aod_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic kind,
  input wire logic [1:0] mode,
  input wire logic [15:0] key,
  input wire logic [4:0] sel,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic nak,
  input wire logic [7:0] rdata,
  input wire logic out_valid,
  input wire logic [15:0] out_code0,
  input wire logic [15:0] out_code1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_full;
  logic rd_sub;
  assign rd_full = req && kind && mode == aod_pkg::AOD_BY_RECORD && key == 16'h0001;
  assign rd_sub = req && kind && mode == aod_pkg::AOD_BY_SUBINDEX;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_ack_next: assert property (req |=> ack)
    else $error("ack missing one cycle after request");
  a_ack_cause: assert property (ack |-> $past(req))
    else $error("ack without a request");
  a_rdata_hold: assert property (!ack |-> $stable(rdata))
    else $error("read data changed without ack");
  a_head_refuse: assert property (req && kind && mode == aod_pkg::AOD_BY_RECORD
    && key == 16'h0000 && sel > 5'h03 |=> nak && rdata == 8'h00)
    else $error("short record answered beyond four bytes");
  a_index_head: assert property (req && kind && mode == aod_pkg::AOD_BY_INDEX
    && key == 16'h2F00 && sel > 5'h03 |-> ##1 nak)
    else $error("short index answered beyond four bytes");
  a_modinfo_byte: assert property (rd_full && sel == 5'h01 |=> !nak && rdata == 8'h15)
    else $error("module information byte wrong");
  a_chan_count: assert property (rd_full && sel == 5'h06 |=> rdata == 8'h02)
    else $error("channel count byte wrong");
  a_sub_kind: assert property (rd_sub && key == 16'h0006 |=> !nak && rdata == 8'h73)
    else $error("channel kind by subindex wrong");
  a_err_bits: assert property (rd_full && (sel == 5'h08 || sel == 5'h09)
    |=> rdata[7:5] == 3'h0 && rdata[3:1] == 3'h0)
    else $error("reserved channel error bits set");
  a_group_bits: assert property (rd_full && sel == 5'h07 |=> rdata[7:2] == 6'h00)
    else $error("reserved group error bits set");
  a_req_hold: assert property (ack |-> $stable(kind) && $stable(mode) &&
    $stable(key) && $stable(sel) && $stable(wdata))
    else $error("request fields changed before the answer");
  a_code_hold: assert property (!out_valid |->
    $stable(out_code0) && $stable(out_code1))
    else $error("output codes changed without a valid strobe");
endmodule

// ### tb/analog_output_param_diag_tb_top.sv
// Bench joining controller and module ends, driving records and output codes
module analog_output_param_diag_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_kind = 1'b0;
  logic [1:0] cmd_mode = 2'h0;
  logic [15:0] cmd_key = 16'h0000;
  logic [4:0] cmd_sel = 5'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic code_valid = 1'b0;
  logic [15:0] code0 = 16'h0000;
  logic [15:0] code1 = 16'h0000;
  logic [1:0] wire_open = 2'h0;
  logic cmd_ready, rsp_valid, rsp_err;
  logic [7:0] rsp_data, last;
  logic [15:0] current_ua0, current_ua1;
  logic [1:0] chan_active, err_led;
  logic [31:0] ts;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  int t_us;
  logic [7:0] fn [4] = '{8'h31, 8'h41, 8'h30, 8'h40};
  int cd [5] = '{27648, 32511, 32767, -3456, 13824};
  logic [4:0] sl [4] = '{5'h01, 5'h04, 5'h05, 5'h06};
  logic [7:0] fb [4] = '{8'h15, 8'h73, 8'h08, 8'h02};

  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= rst ? 0 : cyc + 1;

  aod_link_if aod_link_if_i ();
  aod_host aod_host_i (.clk(clk), .rst(rst), .link(aod_link_if_i), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_mode(cmd_mode), .cmd_key(cmd_key), .cmd_sel(cmd_sel),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
    .rsp_data(rsp_data), .code_valid(code_valid), .code0(code0), .code1(code1));
  aod_device aod_device_i (.clk(clk), .rst(rst), .link(aod_link_if_i), .wire_open(wire_open),
    .current_ua0(current_ua0), .current_ua1(current_ua1), .chan_active(chan_active),
    .err_led(err_led));
  aod_properties aod_properties_i (.clk(clk), .rst(rst), .req(aod_link_if_i.req),
    .kind(aod_link_if_i.kind), .mode(aod_link_if_i.mode), .key(aod_link_if_i.key),
    .sel(aod_link_if_i.sel), .wdata(aod_link_if_i.wdata), .ack(aod_link_if_i.ack),
    .nak(aod_link_if_i.nak), .rdata(aod_link_if_i.rdata), .out_valid(aod_link_if_i.out_valid),
    .out_code0(aod_link_if_i.out_code0), .out_code1(aod_link_if_i.out_code1));

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Sampling on the falling edge keeps one-cycle pulses clear of edge races
  task automatic access(input logic k, input logic [1:0] m, input logic [15:0] ky,
      input logic [4:0] s, input logic [7:0] wd, input logic e_err, input logic [7:0] e_dat,
      input logic cmp);
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (cmd_ready !== 1'b1 && i < 20);
    if (cmd_ready !== 1'b1) begin
      n_fail++;
      close_out();
    end
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_mode <= m;
    cmd_key <= ky;
    cmd_sel <= s;
    cmd_wdata <= wd;
    @(posedge clk);
    cmd_valid <= 1'b0;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (rsp_valid !== 1'b1 && i < 20);
    if (rsp_valid !== 1'b1) begin
      n_fail++;
      close_out();
    end
    last = rsp_data;
    chk(rsp_err, e_err);
    if (cmp) begin
      chk(rsp_data, e_dat);
    end
  endtask

  task automatic rd(input logic [1:0] m, input logic [15:0] ky, input logic [4:0] s,
      input logic e_err, input logic [7:0] e_dat);
    access(1'b1, m, ky, s, 8'h00, e_err, e_dat, 1'b1);
  endtask

  task automatic wr(input logic [1:0] m, input logic [15:0] ky, input logic [4:0] s,
      input logic [7:0] wd);
    access(1'b0, m, ky, s, wd, 1'b0, 8'h00, 1'b0);
  endtask

  task automatic put(input logic [15:0] c0, input logic [15:0] c1);
    @(posedge clk);
    code_valid <= 1'b1;
    code0 <= c0;
    code1 <= c1;
    @(posedge clk);
    code_valid <= 1'b0;
    repeat (6) @(negedge clk);
  endtask

  function automatic int exp_ua(input logic [7:0] f, input int c);
    int fs, ovr, und;
    fs = f[6] ? 16384 : 27648;
    ovr = f[6] ? 20480 : 32511;
    und = f[0] ? 0 : (f[6] ? -4096 : -6912);
    if (c > ovr) c = ovr;
    if (c < und) c = und;
    return f[0] ? c * 20000 / fs : 4000 + c * 16000 / fs;
  endfunction

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(negedge clk);
    chk(chan_active, 2'h3);
    chk(err_led, 2'h0);
    $display("Test reset done");
    for (int i = 0; i < 4; i++) begin
      rd(2'h0, 16'h0001, sl[i], 1'b0, fb[i]);
      rd(2'h1, 16'h2F01, sl[i], 1'b0, fb[i]);
      rd(2'h2, 16'h0002 + 16'(sl[i]), 5'h00, 1'b0, fb[i]);
    end
    rd(2'h0, 16'h0000, 5'h01, 1'b0, 8'h15);
    rd(2'h0, 16'h0000, 5'h04, 1'b1, 8'h00);
    rd(2'h1, 16'h2F00, 5'h04, 1'b1, 8'h00);
    rd(2'h2, 16'h0012, 5'h00, 1'b1, 8'h00);
    rd(2'h0, 16'h0001, 5'h0C, 1'b0, 8'h00);
    rd(2'h0, 16'h0080, 5'h00, 1'b1, 8'h00);
    $display("Test diagnostic layout done");
    for (int f = 0; f < 4; f++) begin
      wr(2'h1, 16'h3102, 5'h00, fn[f]);
      wr(2'h2, 16'h0004, 5'h00, fn[f]);
      rd(2'h0, 16'h0001, 5'h08, 1'b0, 8'h00);
      for (int i = 0; i < 5; i++) begin
        put(16'(cd[i]), 16'(cd[4 - i]));
        chk(current_ua0, exp_ua(fn[f], cd[i]));
        chk(current_ua1, exp_ua(fn[f], cd[4 - i]));
      end
    end
    $display("Test ranges done");
    wr(2'h0, 16'h0080, 5'h00, 8'hFF);
    put(16'h6C00, 16'h6C00);
    chk(chan_active, 2'h2);
    chk(current_ua0, 32'h00000000);
    rd(2'h0, 16'h0001, 5'h08, 1'b0, 8'h00);
    wr(2'h0, 16'h0080, 5'h00, 8'h55);
    t_us = cyc / 40;
    repeat (3) @(negedge clk);
    chk(err_led, 2'h1);
    rd(2'h0, 16'h0001, 5'h08, 1'b0, 8'h01);
    rd(2'h0, 16'h0001, 5'h07, 1'b0, 8'h01);
    rd(2'h0, 16'h0001, 5'h00, 1'b0, 8'h09);
    for (int j = 0; j < 4; j++) begin
      access(1'b1, 2'h0, 16'h0001, 5'h10 + 5'(j), 8'h00, 1'b0, 8'h00, 1'b0);
      ts[j * 8 +: 8] = last;
    end
    chk(ts + 1 >= t_us && ts <= t_us + 1, 1'b1);
    wr(2'h0, 16'h0080, 5'h00, 8'h31);
    repeat (3) @(negedge clk);
    rd(2'h0, 16'h0001, 5'h08, 1'b0, 8'h00);
    $display("Test configuration fault done");
    wr(2'h0, 16'h0000, 5'h01, 8'h02);
    put(16'h0032, 16'h0032);
    chk(current_ua0, exp_ua(8'h31, 50));
    chk(current_ua1, exp_ua(8'h40, 100));
    @(posedge clk);
    wire_open <= 2'h3;
    repeat (6) @(negedge clk);
    chk(err_led, 2'h2);
    rd(2'h0, 16'h0001, 5'h09, 1'b0, 8'h10);
    rd(2'h0, 16'h0001, 5'h08, 1'b0, 8'h00);
    rd(2'h0, 16'h0001, 5'h07, 1'b0, 8'h02);
    @(posedge clk);
    wire_open <= 2'h0;
    repeat (6) @(negedge clk);
    rd(2'h0, 16'h0001, 5'h09, 1'b0, 8'h00);
    $display("Test wire-break done");
    close_out();
  end
endmodule
